// *** dv/adcsc_monitor.sv ***
`default_nettype none
module adcsc_monitor #(
  parameter SMP_W = 10,
  parameter ACC_W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [SMP_W-1:0] analog_data,
  input wire logic analog_done,
  input wire logic deep_sleep_wake,
  input wire logic adc_clk,
  input wire logic sample_switch_closed,
  input wire logic conv_start,
  input wire logic [1:0] reference_sel,
  input wire logic sample_cap_sel,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_done;
  assign wr_done = psel && penable && pwrite && pready;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Sampling phase holds the switch closed for at least two clocks
  sequence s_sampling;
    sample_switch_closed [*2];
  endsequence
  // Switch stays open for the first two clocks while the converter resolves the sample
  sequence s_released;
    !sample_switch_closed [*2];
  endsequence
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  AST_PREADY_ACCESS: assert property (pready |-> psel && penable && $past(psel && penable && !pready))
    else $error("pready outside second access cycle");
  AST_ERR_READ_ZERO: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
    else $error("error response malformed");
  AST_CAP_BY_WRITE: assert property ($changed(sample_cap_sel) |-> $past(wr_done) && $past(paddr) == 8'h08)
    else $error("capacitor select changed without write");
  AST_REF_BY_WRITE: assert property ($changed(reference_sel) |-> $past(wr_done) && $past(paddr) == 8'h08)
    else $error("reference select changed without write");
  AST_SAMPLE_MIN: assert property ($rose(sample_switch_closed) |-> s_sampling)
    else $error("sampling phase too short");
  AST_START_FROM_SAMPLE: assert property (conv_start |-> $past(sample_switch_closed))
    else $error("convert pulse without sampling phase");
  AST_OPEN_AFTER_START: assert property (conv_start |=> s_released)
    else $error("switch closed after convert pulse");
  AST_CONV_PULSE: assert property (conv_start |=> !conv_start)
    else $error("convert pulse longer than one cycle");
  AST_IRQ_HOLD: assert property ($fell(irq) |-> $past(wr_done, 2))
    else $error("irq dropped without register write");
endmodule // adcsc_monitor
bind adcsc_top adcsc_monitor #(.SMP_W(SMP_W), .ACC_W(ACC_W)) u_adcsc_monitor (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .analog_data(analog_data),
  .analog_done(analog_done), .deep_sleep_wake(deep_sleep_wake), .adc_clk(adc_clk),
  .sample_switch_closed(sample_switch_closed), .conv_start(conv_start), .reference_sel(reference_sel),
  .sample_cap_sel(sample_cap_sel), .irq(irq)
);
`default_nettype wire

// *** dv/adcsc_top_tb.sv ***
`include "adcsc_defines.vh"
`default_nettype none
module adcsc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, psel, penable, pwrite, analog_done, deep_sleep_wake, fix_en, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd, flg;
  logic [9:0] analog_data, fix_val;
  wire [31:0] prdata;
  wire pready, pslverr, adc_clk, sample_switch_closed, conv_start, sample_cap_sel, irq;
  wire [1:0] reference_sel;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  int cd = 0;
  int sw_n = 0;
  int sw0 = 0;
  logic [9:0] smp_q[$];
  logic [7:0] rmask[6] = '{8'h00, 8'h07, 8'h77, 8'hff, 8'h07, 8'h1f};
  int vals[5] = '{149, 150, 225, 300, 301};

  adcsc_top u_adcsc_top (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .analog_data(analog_data),
    .analog_done(analog_done), .deep_sleep_wake(deep_sleep_wake), .adc_clk(adc_clk),
    .sample_switch_closed(sample_switch_closed), .conv_start(conv_start), .reference_sel(reference_sel),
    .sample_cap_sel(sample_cap_sel), .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Analog core stand-in: sample ready three clocks after each convert pulse
  always @(posedge clk) begin
    analog_done <= (cd == 1);
    if (cd == 1) smp_q.push_back(analog_data);
    if (conv_start === 1'b1) begin
      cd <= 3;
      analog_data <= fix_en ? fix_val : 10'($urandom);
    end else if (cd > 0) begin
      cd <= cd - 1;
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Latencies vary by up to one converter clock with prescaler phase
  task automatic cmp_near(input int got, input int exp, input string what);
    cmp_count++;
    if (got < exp - 3 || got > exp + 3) begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic apb(input bit wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= idx << 2;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    cmp_val(n, 2, "apb wait states");
  endtask

  // Start, time the convert pulses, collect and clear the flags
  task automatic meas(output int l1, output int l2);
    int n;
    smp_q.delete();
    apb(1, `ADCSC_IDX_CMD, 32'h1);
    n = 0;
    l1 = -1;
    l2 = -1;
    sw_n = 0;
    while (irq !== 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
      if (sample_switch_closed === 1'b1) sw_n++;
      if (conv_start === 1'b1 && l1 < 0) l1 = n;
      else if (conv_start === 1'b1 && l2 < 0) l2 = n - l1;
    end
    apb(0, `ADCSC_IDX_FLAGS, 32'h0);
    flg = rd;
    cmp_val(flg[0], 1'b1, "ready flag");
    apb(1, `ADCSC_IDX_FLAGS, 32'h3);
    repeat (2) @(posedge clk);
    cmp_val(irq, 1'b0, "irq after clear");
  endtask

  function automatic logic win_exp(input int m, input int r);
    case (m)
      1: return r < 300;
      2: return r > 600;
      3: return r > 300 && r < 600;
      4: return r < 300 || r > 600;
      default: return 1'b0;
    endcase
  endfunction

  initial begin
    int l1, l2, b1, b2, d, k, e, a, sum;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    deep_sleep_wake = 1'b0;
    fix_en = 1'b0;
    fix_val = 10'h000;
    void'($urandom(32'hdb12034a));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 1; i < 6; i++) begin
      apb(0, 8'(i), 32'h0);
      cmp_val(rd, 32'h0, "reset value");
      apb(1, 8'(i), 32'hffff_ffff);
      apb(0, 8'(i), 32'h0);
      cmp_val(rd, {24'h0, rmask[i]}, "access mask");
      apb(1, 8'(i), 32'h0);
    end
    apb(0, 8'h07, 32'h0);
    cmp_val(err, 1'b1, "unmapped error");
    cmp_val(rd, 32'h0, "unmapped read");
    $display("Test registers done");
    for (k = 0; k < 8; k++) begin
      d = 1 + $urandom % 2;
      e = $urandom % 2;
      apb(1, `ADCSC_IDX_REFPRE, 32'(k | d << 4 | e << 6));
      @(posedge clk);
      cmp_val({sample_cap_sel, reference_sel}, 32'(e << 2 | d), "ref and cap");
      repeat (3) @(posedge adc_clk);
      l1 = cyc;
      @(posedge adc_clk);
      cmp_val(cyc - l1, 2 << k, "divider");
    end
    $display("Test prescaler done");
    apb(1, `ADCSC_IDX_REFPRE, 32'h10);
    apb(1, `ADCSC_IDX_IEN, 32'h3);
    for (k = 0; k < 8; k++) begin
      d = $urandom % 16;
      e = $urandom % 2;
      a = $urandom % 2;
      apb(1, `ADCSC_IDX_CTRL, 32'(1 | e << 2));
      apb(1, `ADCSC_IDX_ACCUM, k);
      apb(1, `ADCSC_IDX_DELAY, 32'(d | a << 4));
      meas(l1, l2);
      sum = 0;
      foreach (smp_q[i]) sum += e ? smp_q[i] >> 2 : smp_q[i];
      cmp_val(smp_q.size(), k == 7 ? 1 : 1 << k, "sample count");
      apb(0, `ADCSC_IDX_RESULT, 32'h0);
      cmp_val(rd, sum, "result");
      apb(0, `ADCSC_IDX_DELAY, 32'h0);
      cmp_val(rd, 32'(((a ? d + smp_q.size() : d) % 16) | a << 4), "delay field");
    end
    $display("Test accumulation done");
    apb(1, `ADCSC_IDX_CTRL, 32'h1);
    apb(1, `ADCSC_IDX_ACCUM, 32'h1);
    apb(1, `ADCSC_IDX_DELAY, 32'h0);
    meas(b1, b2);
    sw0 = sw_n;
    for (k = 1; k < 8; k++) begin
      apb(1, `ADCSC_IDX_CTRL, 32'h0);
      apb(1, `ADCSC_IDX_CTRL, 32'h1);
      apb(1, `ADCSC_IDX_DELAY, 32'(k << 5));
      meas(l1, l2);
      cmp_near(l1, b1 + 2 * (k > 5 ? 256 : 8 << k), "startup delay");
    end
    meas(l1, l2);
    cmp_near(l1, b1, "no startup when not pending");
    @(posedge clk);
    deep_sleep_wake <= 1'b1;
    @(posedge clk);
    deep_sleep_wake <= 1'b0;
    meas(l1, l2);
    cmp_near(l1, b1 + 512, "startup after wake");
    apb(1, `ADCSC_IDX_DELAY, 32'h0);
    for (e = 1; e < 40; e += 30) begin
      apb(1, `ADCSC_IDX_SAMPLE_EXTEND, e);
      meas(l1, l2);
      cmp_near(l1, b1 + 2 * e, "sample extend");
      cmp_near(l2, b2 + 2 * e, "conversion extend");
    end
    apb(1, `ADCSC_IDX_SAMPLE_EXTEND, 32'h0);
    for (d = 1; d < 16; d += 14) begin
      apb(1, `ADCSC_IDX_DELAY, d);
      meas(l1, l2);
      cmp_near(l2, b2 + 2 * d, "inter-sample gap");
      cmp_near(sw_n, sw0, "switch open in gap");
    end
    $display("Test timing done");
    fix_en = 1'b1;
    apb(1, `ADCSC_IDX_DELAY, 32'h0);
    apb(1, `ADCSC_IDX_WINLO, 32'd300);
    apb(1, `ADCSC_IDX_WINHI, 32'd600);
    for (k = 0; k < 8; k++) begin
      apb(1, `ADCSC_IDX_WINMODE, k);
      foreach (vals[i]) begin
        fix_val = 10'(vals[i]);
        meas(l1, l2);
        cmp_val(flg[1], win_exp(k, 2 * vals[i]), "window flag");
      end
    end
    $display("Test window done");
    fix_en = 1'b0;
    apb(1, `ADCSC_IDX_SAMPLE_EXTEND, 32'd31);
    apb(1, `ADCSC_IDX_CTRL, 32'h3);
    meas(l1, l2);
    apb(0, `ADCSC_IDX_CMD, 32'h0);
    cmp_val(rd[0], 1'b1, "busy after restart");
    d = 0;
    while (irq !== 1'b1 && d < 5000) begin
      @(posedge clk);
      d++;
    end
    cmp_val(irq, 1'b1, "second result without start");
    apb(1, `ADCSC_IDX_CTRL, 32'h1);
    apb(1, `ADCSC_IDX_FLAGS, 32'h3);
    repeat (400) @(posedge clk);
    apb(0, `ADCSC_IDX_CMD, 32'h0);
    cmp_val(rd[0], 1'b0, "idle after single mode");
    $display("Test continuous done");
    test_done();
  end
endmodule // adcsc_top_tb
`default_nettype wire

// *** rtl/adcsc_prescaler.v ***
`include "adcsc_defines.vh"
`default_nettype none
module adcsc_prescaler (
  input wire clk,
  input wire sys_rst,
  input wire [2:0] div_sel,
  output reg conv_tick,
  output reg conv_clk
);
  reg [7:0] cnt_q;
  wire [8:0] div_w;
  wire [8:0] last_w;
  wire [8:0] half_w;

  // Divide by two, doubling per code up to 256
  assign div_w = `ADCSC_DIV_BASE << div_sel;
  assign last_w = div_w - 9'h001;
  assign half_w = {1'b0, div_w[8:1]};

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 8'h00;
      conv_tick <= 1'b0;
      conv_clk <= 1'b0;
    end else begin
      if (cnt_q >= last_w[7:0]) begin
        cnt_q <= 8'h00;
        conv_tick <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 8'h01;
        conv_tick <= 1'b0;
      end
      conv_clk <= ({1'b0, cnt_q} >= half_w);
    end
  end
endmodule // adcsc_prescaler
`default_nettype wire

// *** rtl/adcsc_top.v ***
// What this block does
// - Accumulate 1 to 64 samples by code
// - Sum set into result as one conversion
// - Capacitor select: normal or reduced capacitance
// - Reference: internal, supply or external pin
// - Converter clock is divided by 2 to 256
// - Startup delay 0 to 256 converter clocks
// - Startup delay also after deep sleep wake
// - Inter-sample delay from four-bit field
// - Auto variation increments delay, wraps at 15
// - Sample switch open during inter-sample delay
// - Window mode: off, below, above, inside or outside
// - Compare 16-bit result with 16-bit thresholds
// - Inside mode uses strict bounds both sides
// - Outside mode flags strictly below or above
// - Sampling lasts two plus extension clocks
// - Extension lengthens the whole conversion time
// - Eight-bit mode drops two low bits
// - Interrupt while flag and enable both set
// - Continuous mode restarts after each conversion
//
// Our own choice: the APB interface to the registers.
`include "adcsc_defines.vh"
`default_nettype none
module adcsc_top #(
  parameter SMP_W = 10,
  parameter ACC_W = 16
) (
  input wire clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [SMP_W-1:0] analog_data,
  input wire analog_done,
  input wire deep_sleep_wake,
  output wire adc_clk,
  output wire sample_switch_closed,
  output wire conv_start,
  output wire [1:0] reference_sel,
  output wire sample_cap_sel,
  output wire irq
);
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_INIT = 6'h02;
  localparam [5:0] ST_SAMP = 6'h04;
  localparam [5:0] ST_CONV = 6'h08;
  localparam [5:0] ST_GAP = 6'h10;
  localparam [5:0] ST_DONE = 6'h20;
  localparam [7:0] RST8 = `ADCSC_RST_REG8;
  localparam [15:0] RST16 = `ADCSC_RST_REG16;

  function addr_hit(input [7:0] addr, input [7:0] idx);
    begin
      addr_hit = (addr == {idx[5:0], 2'b00});
    end
  endfunction

  function [6:0] acc_total(input [2:0] code);
    begin
      if (code == `ADCSC_ACC_RSVD) begin
        acc_total = 7'h01;
      end else begin
        acc_total = 7'h01 << code;
      end
    end
  endfunction

  function [8:0] init_len(input [2:0] code);
    begin
      if (code == 3'h0) begin
        init_len = 9'h000;
      end else if (code > `ADCSC_IDLY_MAX_CODE) begin
        init_len = `ADCSC_IDLY_UNIT << `ADCSC_IDLY_MAX_CODE;
      end else begin
        init_len = `ADCSC_IDLY_UNIT << code;
      end
    end
  endfunction

  // Register file
  reg enable_q;
  reg continuous_mode_q;
  reg resolution_sel_q;
  reg [2:0] accum_count_sel_q;
  reg sample_cap_sel_q;
  reg [1:0] reference_sel_q;
  reg [2:0] clock_divider_sel_q;
  reg [2:0] startup_delay_sel_q;
  reg auto_delay_vary_q;
  reg [3:0] inter_sample_delay_q;
  reg [2:0] window_mode_sel_q;
  reg [4:0] sample_extend_q;
  reg [ACC_W-1:0] window_low_threshold_q;
  reg [ACC_W-1:0] window_high_threshold_q;
  reg [ACC_W-1:0] conversion_result_q;
  reg result_ready_en_q;
  reg window_match_en_q;
  reg result_ready_flag_q;
  reg window_match_flag_q;
  reg init_pending_q;
  // Bus answer
  reg [31:0] prdata_q;
  reg pready_q;
  reg pslverr_q;
  reg [31:0] rdata_d;
  reg mapped_d;
  // Sequencer
  reg [5:0] state_q;
  reg [8:0] tcnt_q;
  reg [6:0] nsmp_q;
  reg [ACC_W-1:0] acc_q;
  reg conv_start_q;
  reg switch_q;
  reg irq_q;
  wire conv_tick;
  wire conv_clk;
  wire win_match;
  wire wr_en;
  wire start_req;
  wire [ACC_W-1:0] sample_w;
  wire [SMP_W-1:0] sample_trim;
  wire [8:0] samp_last;
  wire [6:0] nsmp_next;
  wire busy;

  assign wr_en = psel & penable & pready_q & pwrite;
  assign busy = ~state_q[0];
  assign start_req = wr_en & addr_hit(paddr, `ADCSC_IDX_CMD) & pwdata[`ADCSC_START_BIT];
  // Two low bits dropped in eight-bit mode
  assign sample_trim = resolution_sel_q ? (analog_data >> 2) : analog_data;
  assign sample_w = {{(ACC_W-SMP_W){1'b0}}, sample_trim};
  // Two base clocks plus extension
  assign samp_last = {3'h0, `ADCSC_SAMP_BASE + {1'b0, sample_extend_q}} - 9'h001;
  assign nsmp_next = nsmp_q + 7'h01;

  adcsc_prescaler u_clock_divider_sel (
    .clk(clk),
    .sys_rst(sys_rst),
    .div_sel(clock_divider_sel_q),
    .conv_tick(conv_tick),
    .conv_clk(conv_clk)
  );

  adcsc_window #(
    .W(ACC_W)
  ) u_win (
    .result(acc_q),
    .low(window_low_threshold_q),
    .high(window_high_threshold_q),
    .mode(window_mode_sel_q),
    .match(win_match)
  );

  // Read mux and address decode
  always @* begin
    rdata_d = 32'h0000_0000;
    mapped_d = 1'b1;
    if (addr_hit(paddr, `ADCSC_IDX_CTRL)) begin
      rdata_d[`ADCSC_EN_BIT] = enable_q;
      rdata_d[`ADCSC_FREE_BIT] = continuous_mode_q;
      rdata_d[`ADCSC_RES_BIT] = resolution_sel_q;
    end else if (addr_hit(paddr, `ADCSC_IDX_ACCUM)) begin
      rdata_d[`ADCSC_ACC_LSB+2:`ADCSC_ACC_LSB] = accum_count_sel_q;
    end else if (addr_hit(paddr, `ADCSC_IDX_REFPRE)) begin
      rdata_d[`ADCSC_DIV_LSB+2:`ADCSC_DIV_LSB] = clock_divider_sel_q;
      rdata_d[`ADCSC_REF_LSB+1:`ADCSC_REF_LSB] = reference_sel_q;
      rdata_d[`ADCSC_CAP_BIT] = sample_cap_sel_q;
    end else if (addr_hit(paddr, `ADCSC_IDX_DELAY)) begin
      rdata_d[`ADCSC_SDLY_LSB+3:`ADCSC_SDLY_LSB] = inter_sample_delay_q;
      rdata_d[`ADCSC_AUTO_DELAY_VARY_BIT] = auto_delay_vary_q;
      rdata_d[`ADCSC_IDLY_LSB+2:`ADCSC_IDLY_LSB] = startup_delay_sel_q;
    end else if (addr_hit(paddr, `ADCSC_IDX_WINMODE)) begin
      rdata_d[`ADCSC_WIN_LSB+2:`ADCSC_WIN_LSB] = window_mode_sel_q;
    end else if (addr_hit(paddr, `ADCSC_IDX_SAMPLE_EXTEND)) begin
      rdata_d[`ADCSC_SLEN_LSB+4:`ADCSC_SLEN_LSB] = sample_extend_q;
    end else if (addr_hit(paddr, `ADCSC_IDX_CMD)) begin
      rdata_d[`ADCSC_START_BIT] = busy;
    end else if (addr_hit(paddr, `ADCSC_IDX_IEN)) begin
      rdata_d[`ADCSC_RR_BIT] = result_ready_en_q;
      rdata_d[`ADCSC_WM_BIT] = window_match_en_q;
    end else if (addr_hit(paddr, `ADCSC_IDX_FLAGS)) begin
      rdata_d[`ADCSC_RR_BIT] = result_ready_flag_q;
      rdata_d[`ADCSC_WM_BIT] = window_match_flag_q;
    end else if (addr_hit(paddr, `ADCSC_IDX_RESULT)) begin
      rdata_d[ACC_W-1:0] = conversion_result_q;
    end else if (addr_hit(paddr, `ADCSC_IDX_WINLO)) begin
      rdata_d[ACC_W-1:0] = window_low_threshold_q;
    end else if (addr_hit(paddr, `ADCSC_IDX_WINHI)) begin
      rdata_d[ACC_W-1:0] = window_high_threshold_q;
    end else begin
      mapped_d = 1'b0;
    end
  end

  // APB answer, one wait state per access
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel & penable & ~pready_q;
      if (psel & penable & ~pready_q) begin
        pslverr_q <= ~mapped_d;
        prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // Configuration registers
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      enable_q <= RST8[`ADCSC_EN_BIT];
      continuous_mode_q <= RST8[`ADCSC_FREE_BIT];
      resolution_sel_q <= RST8[`ADCSC_RES_BIT];
      accum_count_sel_q <= RST8[2:0];
      sample_cap_sel_q <= RST8[`ADCSC_CAP_BIT];
      reference_sel_q <= RST8[1:0];
      clock_divider_sel_q <= RST8[2:0];
      startup_delay_sel_q <= RST8[2:0];
      auto_delay_vary_q <= RST8[`ADCSC_AUTO_DELAY_VARY_BIT];
      window_mode_sel_q <= RST8[2:0];
      sample_extend_q <= RST8[4:0];
      window_low_threshold_q <= RST16[ACC_W-1:0];
      window_high_threshold_q <= RST16[ACC_W-1:0];
      result_ready_en_q <= RST8[0];
      window_match_en_q <= RST8[0];
    end else if (wr_en & ~pslverr_q) begin
      if (addr_hit(paddr, `ADCSC_IDX_CTRL)) begin
        enable_q <= pwdata[`ADCSC_EN_BIT];
        continuous_mode_q <= pwdata[`ADCSC_FREE_BIT];
        resolution_sel_q <= pwdata[`ADCSC_RES_BIT];
      end
      if (addr_hit(paddr, `ADCSC_IDX_ACCUM)) begin
        accum_count_sel_q <= pwdata[`ADCSC_ACC_LSB+2:`ADCSC_ACC_LSB];
      end
      if (addr_hit(paddr, `ADCSC_IDX_REFPRE)) begin
        clock_divider_sel_q <= pwdata[`ADCSC_DIV_LSB+2:`ADCSC_DIV_LSB];
        reference_sel_q <= pwdata[`ADCSC_REF_LSB+1:`ADCSC_REF_LSB];
        sample_cap_sel_q <= pwdata[`ADCSC_CAP_BIT];
      end
      if (addr_hit(paddr, `ADCSC_IDX_DELAY)) begin
        auto_delay_vary_q <= pwdata[`ADCSC_AUTO_DELAY_VARY_BIT];
        startup_delay_sel_q <= pwdata[`ADCSC_IDLY_LSB+2:`ADCSC_IDLY_LSB];
      end
      if (addr_hit(paddr, `ADCSC_IDX_WINMODE)) begin
        window_mode_sel_q <= pwdata[`ADCSC_WIN_LSB+2:`ADCSC_WIN_LSB];
      end
      if (addr_hit(paddr, `ADCSC_IDX_SAMPLE_EXTEND)) begin
        sample_extend_q <= pwdata[`ADCSC_SLEN_LSB+4:`ADCSC_SLEN_LSB];
      end
      if (addr_hit(paddr, `ADCSC_IDX_IEN)) begin
        result_ready_en_q <= pwdata[`ADCSC_RR_BIT];
        window_match_en_q <= pwdata[`ADCSC_WM_BIT];
      end
      if (addr_hit(paddr, `ADCSC_IDX_WINLO)) begin
        window_low_threshold_q <= pwdata[ACC_W-1:0];
      end
      if (addr_hit(paddr, `ADCSC_IDX_WINHI)) begin
        window_high_threshold_q <= pwdata[ACC_W-1:0];
      end
    end
  end

  // Sampling delay, software write wins over auto increment
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      inter_sample_delay_q <= RST8[3:0];
    end else if (wr_en & addr_hit(paddr, `ADCSC_IDX_DELAY)) begin
      inter_sample_delay_q <= pwdata[`ADCSC_SDLY_LSB+3:`ADCSC_SDLY_LSB];
    end else if (state_q[3] & analog_done & auto_delay_vary_q) begin
      inter_sample_delay_q <= inter_sample_delay_q + 4'h1;
    end
  end

  // Startup delay request: enable, switch to internal reference, wake
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      init_pending_q <= 1'b0;
    end else if (wr_en & addr_hit(paddr, `ADCSC_IDX_CTRL) & pwdata[`ADCSC_EN_BIT] & ~enable_q) begin
      init_pending_q <= 1'b1;
    end else if (wr_en & addr_hit(paddr, `ADCSC_IDX_REFPRE)
                 & (pwdata[`ADCSC_REF_LSB+1:`ADCSC_REF_LSB] == `ADCSC_REF_INTERNAL)
                 & (reference_sel_q != `ADCSC_REF_INTERNAL)) begin
      init_pending_q <= 1'b1;
    end else if (deep_sleep_wake) begin
      init_pending_q <= 1'b1;
    end else if (state_q[1] & (tcnt_q >= init_len(startup_delay_sel_q))) begin
      init_pending_q <= 1'b0;
    end
  end

  // Conversion sequencer
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      tcnt_q <= 9'h000;
      nsmp_q <= 7'h00;
      acc_q <= RST16[ACC_W-1:0];
      conv_start_q <= 1'b0;
      conversion_result_q <= RST16[ACC_W-1:0];
    end else if (!enable_q) begin
      state_q <= ST_IDLE;
      tcnt_q <= 9'h000;
      conv_start_q <= 1'b0;
    end else begin
      conv_start_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start_req) begin
            acc_q <= RST16[ACC_W-1:0];
            nsmp_q <= 7'h00;
            tcnt_q <= 9'h000;
            state_q <= init_pending_q ? ST_INIT : ST_SAMP;
          end
        end
        ST_INIT: begin
          if (tcnt_q >= init_len(startup_delay_sel_q)) begin
            tcnt_q <= 9'h000;
            state_q <= ST_SAMP;
          end else if (conv_tick) begin
            tcnt_q <= tcnt_q + 9'h001;
          end
        end
        ST_SAMP: begin
          if (conv_tick) begin
            if (tcnt_q >= samp_last) begin
              tcnt_q <= 9'h000;
              conv_start_q <= 1'b1;
              state_q <= ST_CONV;
            end else begin
              tcnt_q <= tcnt_q + 9'h001;
            end
          end
        end
        ST_CONV: begin
          if (analog_done) begin
            acc_q <= acc_q + sample_w;
            nsmp_q <= nsmp_next;
            tcnt_q <= 9'h000;
            if (nsmp_next >= acc_total(accum_count_sel_q)) begin
              state_q <= ST_DONE;
            end else begin
              state_q <= ST_GAP;
            end
          end
        end
        ST_GAP: begin
          if (tcnt_q >= {5'h00, inter_sample_delay_q}) begin
            tcnt_q <= 9'h000;
            state_q <= ST_SAMP;
          end else if (conv_tick) begin
            tcnt_q <= tcnt_q + 9'h001;
          end
        end
        ST_DONE: begin
          conversion_result_q <= acc_q;
          acc_q <= RST16[ACC_W-1:0];
          nsmp_q <= 7'h00;
          tcnt_q <= 9'h000;
          if (continuous_mode_q) begin
            state_q <= ST_SAMP;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Flags: write one clears, a same-cycle set wins
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      result_ready_flag_q <= 1'b0;
      window_match_flag_q <= 1'b0;
    end else begin
      if (state_q[5]) begin
        result_ready_flag_q <= 1'b1;
      end else if (wr_en & addr_hit(paddr, `ADCSC_IDX_FLAGS) & pwdata[`ADCSC_RR_BIT]) begin
        result_ready_flag_q <= 1'b0;
      end
      if (state_q[5] & win_match) begin
        window_match_flag_q <= 1'b1;
      end else if (wr_en & addr_hit(paddr, `ADCSC_IDX_FLAGS) & pwdata[`ADCSC_WM_BIT]) begin
        window_match_flag_q <= 1'b0;
      end
    end
  end

  // Sample switch and interrupt outputs
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      switch_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      switch_q <= state_q[2] & enable_q;
      irq_q <= (result_ready_flag_q & result_ready_en_q)
               | (window_match_flag_q & window_match_en_q);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign adc_clk = conv_clk;
  assign sample_switch_closed = switch_q;
  assign conv_start = conv_start_q;
  assign reference_sel = reference_sel_q;
  assign sample_cap_sel = sample_cap_sel_q;
  assign irq = irq_q;
endmodule // adcsc_top
`default_nettype wire

// *** rtl/adcsc_window.v ***
`include "adcsc_defines.vh"
`default_nettype none
module adcsc_window #(
  parameter W = 16
) (
  input wire [W-1:0] result,
  input wire [W-1:0] low,
  input wire [W-1:0] high,
  input wire [2:0] mode,
  output reg match
);
  always @* begin
    case (mode)
      `ADCSC_WIN_BELOW: match = (result < low);
      `ADCSC_WIN_ABOVE: match = (result > high);
      `ADCSC_WIN_INSIDE: match = (result > low) && (result < high);
      `ADCSC_WIN_OUTSIDE: match = (result < low) || (result > high);
      default: match = 1'b0;
    endcase
  end
endmodule // adcsc_window
`default_nettype wire

// *** shared/adcsc_defines.vh ***
`ifndef ADCSC_DEFINES_VH
`define ADCSC_DEFINES_VH
// Register indices, byte address is four times the index
`define ADCSC_IDX_CTRL 8'h00
`define ADCSC_IDX_ACCUM 8'h01
`define ADCSC_IDX_REFPRE 8'h02
`define ADCSC_IDX_DELAY 8'h03
`define ADCSC_IDX_WINMODE 8'h04
`define ADCSC_IDX_SAMPLE_EXTEND 8'h05
`define ADCSC_IDX_CMD 8'h08
`define ADCSC_IDX_IEN 8'h0a
`define ADCSC_IDX_FLAGS 8'h0b
`define ADCSC_IDX_RESULT 8'h10
`define ADCSC_IDX_WINLO 8'h12
`define ADCSC_IDX_WINHI 8'h14
// Field positions
`define ADCSC_EN_BIT 0
`define ADCSC_FREE_BIT 1
`define ADCSC_RES_BIT 2
`define ADCSC_ACC_LSB 0
`define ADCSC_DIV_LSB 0
`define ADCSC_REF_LSB 4
`define ADCSC_CAP_BIT 6
`define ADCSC_SDLY_LSB 0
`define ADCSC_AUTO_DELAY_VARY_BIT 4
`define ADCSC_IDLY_LSB 5
`define ADCSC_WIN_LSB 0
`define ADCSC_SLEN_LSB 0
`define ADCSC_START_BIT 0
`define ADCSC_RR_BIT 0
`define ADCSC_WM_BIT 1
// Reset values
`define ADCSC_RST_REG8 8'h00
`define ADCSC_RST_REG16 16'h0000
// Codes
`define ADCSC_ACC_RSVD 3'h7
`define ADCSC_REF_INTERNAL 2'h0
`define ADCSC_WIN_NONE 3'h0
`define ADCSC_WIN_BELOW 3'h1
`define ADCSC_WIN_ABOVE 3'h2
`define ADCSC_WIN_INSIDE 3'h3
`define ADCSC_WIN_OUTSIDE 3'h4
// Counts in converter clocks, divider base in system clocks
`define ADCSC_SAMP_BASE 6'h02
`define ADCSC_IDLY_UNIT 9'h008
`define ADCSC_IDLY_MAX_CODE 3'h5
`define ADCSC_DIV_BASE 9'h002
`endif
